/* File: core/plcl_base_div.sv */
`timescale 1ns/1ps
`include "plcl_params.svh"
// Base clock divider: oscillator by two, VCO by three, held low when halted
module plcl_base_div
   import plcl_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   plcl_clk_if.div cif
);
   logic src_ff, nxt_src;
   logic sel_ff, nxt_sel;
   logic [1:0] cnt_ff, nxt_cnt;
   logic out_ff, nxt_out;
   logic cur_src;
   logic [1:0] edges;

   // Count edges of the selected source, toggle after the divide count
   always_comb
   begin
      cur_src = cif.src_sel ? cif.vco_clk : cif.osc_clk;
      edges = cif.src_sel ? `PLCL_VCO_EDGES : `PLCL_OSC_EDGES;
      nxt_src = cur_src;
      nxt_sel = cif.src_sel;
      nxt_cnt = cnt_ff;
      nxt_out = out_ff;
      if (cif.halt)
      begin
         nxt_cnt = 2'h0;
         nxt_out = 1'b0;
      end
      else if (cif.src_sel != sel_ff)
      begin
         nxt_cnt = 2'h0; // Output held while the source changes
      end
      else if (cur_src != src_ff)
      begin
         if (cnt_ff == edges - 2'h1)
         begin
            nxt_cnt = 2'h0;
            nxt_out = !out_ff;
         end
         else
         begin
            nxt_cnt = cnt_ff + 2'h1;
         end
      end
   end

   // Divider state
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         src_ff <= 1'b0;
         sel_ff <= 1'b0;
         cnt_ff <= 2'h0;
         out_ff <= 1'b0;
      end
      else
      begin
         src_ff <= nxt_src;
         sel_ff <= nxt_sel;
         cnt_ff <= nxt_cnt;
         out_ff <= nxt_out;
      end
   end

   assign cif.base_clk = out_ff;
endmodule // plcl_base_div

/* File: core/plcl_clk_if.sv */
`timescale 1ns/1ps
// Base clock path between control logic and divider
interface plcl_clk_if;
   logic src_sel;
   logic halt;
   logic osc_clk;
   logic vco_clk;
   logic base_clk;
   modport ctrl (output src_sel, output halt, output osc_clk, output vco_clk, input base_clk);
   modport div (input src_sel, input halt, input osc_clk, input vco_clk, output base_clk);
endinterface // plcl_clk_if

/* File: core/plcl_loop_ctrl.sv */
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "plcl_params.svh"
module plcl_loop_ctrl
   import plcl_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic oscillator_clock,
   input wire logic vco_clock,
   input wire logic lock_detect,
   input wire logic track_detect,
   input wire logic stop_mode,
   input wire logic osc_run_in_halt,
   input wire logic break_state,
   input wire logic break_clear_enable,
   output logic base_clock_out,
   output logic vco_clock_out,
   output logic loop_irq_out,
   output logic loop_active,
   output logic osc_enable,
   output logic auto_bandwidth,
   output logic capture_or_track_select,
   output logic [11:0] feedback_multiplier,
   output logic [7:0] vco_range_value,
   output logic [3:0] reference_divide_value,
   output logic [1:0] prescale_value,
   output logic [1:0] vco_power_value
);
   plcl_sel_t reg_sel;
   logic [3:0] sync_q;
   logic osc_s, vco_s, lock_s, track_s;
   logic auto_ff, nxt_auto;
   logic capture_keep_ff, nxt_capture_keep;
   logic ie_ff, nxt_ie;
   logic flag_ff, nxt_flag;
   logic on_ff, nxt_on;
   logic src_vco_ff, nxt_src_vco;
   logic [1:0] pre_ff, nxt_pre;
   logic [1:0] vpr_ff, nxt_vpr;
   logic [11:0] mul_ff, nxt_mul;
   logic [7:0] range_ff, nxt_range;
   logic [3:0] refdiv_ff, nxt_refdiv;
   logic lock_prev_ff, nxt_lock_prev;
   logic [7:0] rdata_ff, nxt_rdata;
   logic vco_out_ff, nxt_vco_out;
   logic lock_evt, flag_clr, halt_osc, loop_on;
   logic wr_ctrl, wr_bw;

   plcl_clk_if cif ();

   // Clock and lock/track detector inputs pass two flops first
   plcl_sync #(.W(4)) u_sync (
      .mclk(mclk),
      .resetn(resetn),
      .async_in({track_detect, lock_detect, vco_clock, oscillator_clock}),
      .sync_out(sync_q)
   );
   assign osc_s = sync_q[0];
   assign vco_s = sync_q[1];
   assign lock_s = sync_q[2];
   assign track_s = sync_q[3];

   // Address decode
   always_comb
   begin
      if (reg_addr == `PLCL_OFS_LOOP_CONTROL)
         reg_sel = PLCL_SEL_CTRL;
      else if (reg_addr == `PLCL_OFS_LOOP_BANDWIDTH_CONTROL)
         reg_sel = PLCL_SEL_BW;
      else if (reg_addr == `PLCL_OFS_FEEDBACK_MULTIPLIER_HIGH)
         reg_sel = PLCL_SEL_MUL_HI;
      else if (reg_addr == `PLCL_OFS_FEEDBACK_MULTIPLIER_LOW)
         reg_sel = PLCL_SEL_MUL_LO;
      else if (reg_addr == `PLCL_OFS_VCO_RANGE_SELECT)
         reg_sel = PLCL_SEL_RANGE;
      else if (reg_addr == `PLCL_OFS_REFERENCE_DIVIDER_SELECT)
         reg_sel = PLCL_SEL_REFDIV;
      else
         reg_sel = PLCL_SEL_NONE;
   end

   // Stop handling; wait mode has no input and no effect
   assign halt_osc = stop_mode && !osc_run_in_halt;
   assign loop_on = on_ff && (range_ff != 8'h00) && !stop_mode;
   assign wr_ctrl = reg_wr && (reg_sel == PLCL_SEL_CTRL);
   assign wr_bw = reg_wr && (reg_sel == PLCL_SEL_BW);

   // Lock change events and read-side clearing of the flag
   assign lock_evt = auto_ff && (lock_s != lock_prev_ff);
   assign flag_clr = reg_rd && (reg_sel == PLCL_SEL_CTRL) && !(break_state && !break_clear_enable);

   // Next values of the register file
   always_comb
   begin
      nxt_auto = auto_ff;
      nxt_capture_keep = capture_keep_ff;
      nxt_ie = ie_ff;
      nxt_on = on_ff;
      nxt_src_vco = src_vco_ff;
      nxt_pre = pre_ff;
      nxt_vpr = vpr_ff;
      nxt_mul = mul_ff;
      nxt_range = range_ff;
      nxt_refdiv = refdiv_ff;
      nxt_lock_prev = lock_s;
      nxt_vco_out = loop_on && vco_s;
      nxt_rdata = 8'h00;
      // Set wins over a read clear in the same cycle
      if (lock_evt)
         nxt_flag = 1'b1;
      else if (flag_clr)
         nxt_flag = 1'b0;
      else
         nxt_flag = flag_ff;
      if (wr_bw)
      begin
         nxt_auto = reg_wdata[`PLCL_BIT_AUTO];
         if (!auto_ff)
            nxt_capture_keep = reg_wdata[`PLCL_BIT_TRACK];
      end
      if (wr_ctrl)
      begin
         if (auto_ff)
            nxt_ie = reg_wdata[`PLCL_BIT_IRQ_ENABLE];
         if (reg_wdata[`PLCL_BIT_LOOP_ENABLE])
            nxt_on = 1'b1;
         else if (!src_vco_ff)
            nxt_on = 1'b0;
         if (!reg_wdata[`PLCL_BIT_BASE_SELECT])
            nxt_src_vco = 1'b0;
         else if (on_ff && (range_ff != 8'h00))
            nxt_src_vco = 1'b1;
         if (!on_ff)
         begin
            nxt_pre = reg_wdata[`PLCL_PRE_HI:`PLCL_PRE_LO];
            nxt_vpr = reg_wdata[`PLCL_VPR_HI:`PLCL_VPR_LO];
         end
      end
      // Configuration writes are frozen while the loop is enabled
      if (reg_wr && !on_ff)
      begin
         if (reg_sel == PLCL_SEL_MUL_HI)
            nxt_mul[11:8] = reg_wdata[3:0];
         else if (reg_sel == PLCL_SEL_MUL_LO)
            nxt_mul[7:0] = reg_wdata;
         else if (reg_sel == PLCL_SEL_RANGE)
            nxt_range = reg_wdata;
         else if (reg_sel == PLCL_SEL_REFDIV)
            nxt_refdiv = reg_wdata[3:0];
      end
      // Zero range or stop forces the oscillator source
      if ((range_ff == 8'h00) || stop_mode)
         nxt_src_vco = 1'b0;
      // Read data, one cycle after the strobe
      if (reg_rd)
      begin
         if (reg_sel == PLCL_SEL_CTRL)
            nxt_rdata = {ie_ff && auto_ff, flag_ff && auto_ff, on_ff, src_vco_ff, pre_ff, vpr_ff};
         else if (reg_sel == PLCL_SEL_BW)
            nxt_rdata = {auto_ff, lock_s && auto_ff, auto_ff ? track_s : capture_keep_ff, 5'h00};
         else if (reg_sel == PLCL_SEL_MUL_HI)
            nxt_rdata = {4'h0, mul_ff[11:8]};
         else if (reg_sel == PLCL_SEL_MUL_LO)
            nxt_rdata = mul_ff[7:0];
         else if (reg_sel == PLCL_SEL_RANGE)
            nxt_rdata = range_ff;
         else if (reg_sel == PLCL_SEL_REFDIV)
            nxt_rdata = {4'h0, refdiv_ff};
      end
   end

   // Register file flops
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         auto_ff <= 1'b0;
         capture_keep_ff <= 1'b0;
         ie_ff <= 1'b0;
         flag_ff <= 1'b0;
         on_ff <= `PLCL_RST_LOOP_ENABLE;
         src_vco_ff <= 1'b0;
         pre_ff <= 2'h0;
         vpr_ff <= 2'h0;
         mul_ff <= `PLCL_RST_MUL;
         range_ff <= `PLCL_RST_RANGE;
         refdiv_ff <= `PLCL_RST_REFDIV;
         lock_prev_ff <= 1'b0;
         rdata_ff <= 8'h00;
         vco_out_ff <= 1'b0;
      end
      else
      begin
         auto_ff <= nxt_auto;
         capture_keep_ff <= nxt_capture_keep;
         ie_ff <= nxt_ie;
         flag_ff <= nxt_flag;
         on_ff <= nxt_on;
         src_vco_ff <= nxt_src_vco;
         pre_ff <= nxt_pre;
         vpr_ff <= nxt_vpr;
         mul_ff <= nxt_mul;
         range_ff <= nxt_range;
         refdiv_ff <= nxt_refdiv;
         lock_prev_ff <= nxt_lock_prev;
         rdata_ff <= nxt_rdata;
         vco_out_ff <= nxt_vco_out;
      end
   end

   // Base clock divider hookup
   assign cif.src_sel = src_vco_ff;
   assign cif.halt = halt_osc;
   assign cif.osc_clk = osc_s;
   assign cif.vco_clk = vco_s;
   plcl_base_div u_div (
      .mclk(mclk),
      .resetn(resetn),
      .cif(cif)
   );

   // Outputs toward the analog loop and the system
   assign base_clock_out = cif.base_clk;
   assign vco_clock_out = vco_out_ff;
   assign loop_irq_out = auto_ff && ie_ff && flag_ff && !halt_osc;
   assign loop_active = loop_on;
   assign osc_enable = !halt_osc;
   assign auto_bandwidth = auto_ff;
   assign capture_or_track_select = capture_keep_ff;
   assign feedback_multiplier = (mul_ff == 12'h000) ? 12'h001 : mul_ff;
   assign vco_range_value = range_ff;
   assign reference_divide_value = (refdiv_ff == 4'h0) ? 4'h1 : refdiv_ff;
   assign prescale_value = pre_ff;
   assign vco_power_value = vpr_ff;
   assign reg_rdata = rdata_ff;

   // Checks on the control logic
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   property p_lock_manual;
      (reg_rd && reg_sel == PLCL_SEL_BW && !auto_ff) |=> (reg_rdata[`PLCL_BIT_LOCK] == 1'b0);
   endproperty
   a_lock_manual: assert property (p_lock_manual) else $error("lock bit nonzero in manual mode");

   property p_flag_set;
      (auto_ff && lock_s != lock_prev_ff) |=> flag_ff;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("lock change did not set flag");

   property p_manual_quiet;
      !auto_ff |-> !loop_irq_out;
   endproperty
   a_manual_quiet: assert property (p_manual_quiet) else $error("request in manual mode");

   property p_cfg_frozen;
      (reg_wr && on_ff && reg_sel == PLCL_SEL_MUL_LO) |=> $stable(mul_ff);
   endproperty
   a_cfg_frozen: assert property (p_cfg_frozen) else $error("multiplier written while loop on");

   property p_src_guard;
      $rose(src_vco_ff) |-> ($past(on_ff) && $past(range_ff) != 8'h00);
   endproperty
   a_src_guard: assert property (p_src_guard) else $error("base select set without loop or range");

   property p_on_held;
      (src_vco_ff && on_ff) |=> on_ff;
   endproperty
   a_on_held: assert property (p_on_held) else $error("loop enable cleared under base select");

   property p_stop_src;
      stop_mode |=> !src_vco_ff;
   endproperty
   a_stop_src: assert property (p_stop_src) else $error("base select survived stop");

   property p_halt_low;
      (halt_osc ##1 halt_osc) |-> (!base_clock_out && !vco_clock_out && !loop_irq_out);
   endproperty
   a_halt_low: assert property (p_halt_low) else $error("outputs active in halting stop");

   property p_break_keep;
      (reg_rd && reg_sel == PLCL_SEL_CTRL && break_state && !break_clear_enable && flag_ff) |=> flag_ff;
   endproperty
   a_break_keep: assert property (p_break_keep) else $error("flag cleared in protected break");

   property p_read_clear;
      (flag_clr && !lock_evt) |=> !flag_ff;
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("control read did not clear flag");

   property p_shadow;
      (auto_ff ##1 !auto_ff) |-> (capture_keep_ff == $past(capture_keep_ff));
   endproperty
   a_shadow: assert property (p_shadow) else $error("manual capture value lost");

   // Main scenarios
   c_flag_set: cover property (lock_evt ##1 flag_ff);
   c_src_set: cover property ($rose(src_vco_ff));
   c_shadow_back: cover property (auto_ff ##1 !auto_ff);
   c_stop_halt: cover property ($rose(halt_osc));
   c_read_clear: cover property (flag_ff && flag_clr ##1 !flag_ff);
endmodule // plcl_loop_ctrl

/* File: core/plcl_params.svh */
`ifndef PLCL_PARAMS_SVH
`define PLCL_PARAMS_SVH

// Register offsets on the 3-bit register port
`define PLCL_OFS_LOOP_CONTROL 3'h0
`define PLCL_OFS_LOOP_BANDWIDTH_CONTROL 3'h1
`define PLCL_OFS_FEEDBACK_MULTIPLIER_HIGH 3'h2
`define PLCL_OFS_FEEDBACK_MULTIPLIER_LOW 3'h3
`define PLCL_OFS_VCO_RANGE_SELECT 3'h4
`define PLCL_OFS_REFERENCE_DIVIDER_SELECT 3'h5

// Loop control register fields
`define PLCL_BIT_IRQ_ENABLE 7
`define PLCL_BIT_CHANGE_FLAG 6
`define PLCL_BIT_LOOP_ENABLE 5
`define PLCL_BIT_BASE_SELECT 4
`define PLCL_PRE_HI 3
`define PLCL_PRE_LO 2
`define PLCL_VPR_HI 1
`define PLCL_VPR_LO 0

// Bandwidth control register fields
`define PLCL_BIT_AUTO 7
`define PLCL_BIT_LOCK 6
`define PLCL_BIT_TRACK 5

// Reset values
`define PLCL_RST_MUL 12'h040
`define PLCL_RST_RANGE 8'h40
`define PLCL_RST_REFDIV 4'h1
`define PLCL_RST_LOOP_ENABLE 1'b1

// Base clock division, counted in source clock edges (both edges)
`define PLCL_OSC_EDGES 2'h2
`define PLCL_VCO_EDGES 2'h3

`endif

/* File: core/plcl_pkg.sv */
package plcl_pkg;

   // Register selected by the current bus address
   typedef enum logic [2:0] {
      PLCL_SEL_NONE = 3'b000,
      PLCL_SEL_CTRL = 3'b001,
      PLCL_SEL_BW = 3'b010,
      PLCL_SEL_MUL_HI = 3'b011,
      PLCL_SEL_MUL_LO = 3'b100,
      PLCL_SEL_RANGE = 3'b101,
      PLCL_SEL_REFDIV = 3'b110
   } plcl_sel_t;

endpackage

/* File: core/plcl_sync.sv */
`timescale 1ns/1ps
// Two-stage synchroniser, one pair of flops per bit
module plcl_sync #(
   parameter int W = 4
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;

   genvar gi;
   generate
      for (gi = 0; gi < W; gi++)
      begin : g_bit
         // First stage feeds only the second stage
         always_ff @(posedge mclk or negedge resetn)
         begin
            if (!resetn)
            begin
               meta_ff[gi] <= 1'b0;
               sync_ff[gi] <= 1'b0;
            end
            else
            begin
               meta_ff[gi] <= async_in[gi];
               sync_ff[gi] <= meta_ff[gi];
            end
         end
      end
   endgenerate

   assign sync_out = sync_ff;
endmodule // plcl_sync

/* File: sim/plcl_sim_model.sv */
`timescale 1ns/1ps
// System integration side: consumes the base clock and counts its rising edges
module plcl_sim_model (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic base_clock_out,
   output logic [15:0] edge_cnt
);
   logic last_ff;

   // Edge counter on the registered base clock
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         last_ff <= 1'b0;
         edge_cnt <= 16'h0000;
      end
      else
      begin
         last_ff <= base_clock_out;
         if (base_clock_out && !last_ff)
            edge_cnt <= edge_cnt + 16'h0001;
      end
   end
endmodule // plcl_sim_model

/* File: sim/tb.sv */
`timescale 1ns/1ps
module tb;
   logic mclk, resetn, reg_wr, reg_rd, osc_clk, vco_clk, lock_det, trk_det;
   logic stop_m, run_halt, brk, bce, base_out, vco_out, irq_out, loop_act, osc_en, auto_bw, cts;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, rng_out;
   logic [11:0] fmul;
   logic [3:0] rdiv_out;
   logic [1:0] pre, vpr;
   logic [15:0] ecnt;
   int failures, tests_run;

   plcl_loop_ctrl dut (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .oscillator_clock(osc_clk),
      .vco_clock(vco_clk), .lock_detect(lock_det), .track_detect(trk_det), .stop_mode(stop_m),
      .osc_run_in_halt(run_halt), .break_state(brk), .break_clear_enable(bce),
      .base_clock_out(base_out), .vco_clock_out(vco_out), .loop_irq_out(irq_out),
      .loop_active(loop_act), .osc_enable(osc_en), .auto_bandwidth(auto_bw),
      .capture_or_track_select(cts), .feedback_multiplier(fmul), .vco_range_value(rng_out),
      .reference_divide_value(rdiv_out), .prescale_value(pre), .vco_power_value(vpr));

   plcl_sim_model u_partner (.mclk(mclk), .resetn(resetn), .base_clock_out(base_out), .edge_cnt(ecnt));

   // Bus clock 25 ns, slow oscillator 200 ns and VCO 300 ns sources
   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   initial
   begin
      osc_clk = 1'b0;
      forever #100 osc_clk = ~osc_clk;
   end
   initial
   begin
      vco_clk = 1'b0;
      forever #150 vco_clk = ~vco_clk;
   end

   task automatic summarize;
      $display("tests run %0d, failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // Register port write and read, strobes one cycle long
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   task automatic rdc(input logic [2:0] a, input logic [7:0] e, input string m);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e, m);
   endtask

   // Counts base clock edges over 3600 ns after letting the source switch settle
   task automatic rate(input int lo, input int hi, input string m);
      logic [15:0] c0;
      repeat (48) @(posedge mclk);
      c0 = ecnt;
      repeat (144) @(posedge mclk);
      c0 = ecnt - c0;
      tests_run++;
      if ((c0 >= lo && c0 <= hi) !== 1'b1)
      begin
         failures++;
         $display("unexpected at %0t: %s edges %0d", $time, m, c0);
      end
   endtask

   task automatic wirq(input logic e);
      int n;
      n = 0;
      while (irq_out !== e && n < 12)
      begin
         @(posedge mclk);
         #1;
         n++;
      end
      chk(irq_out, e, "irq level");
      if (irq_out !== e)
         summarize();
   endtask

   task automatic t_reset;
      rdc(3'h0, 8'h20, "ctrl reset");
      rdc(3'h1, 8'h00, "bw reset");
      rdc(3'h2, 8'h00, "mul hi reset");
      rdc(3'h3, 8'h40, "mul lo reset");
      rdc(3'h4, 8'h40, "range reset");
      rdc(3'h5, 8'h01, "refdiv reset");
      rdc(3'h6, 8'h00, "unmapped");
      $display("test reset done");
   endtask

   task automatic t_cfg;
      wr(3'h3, 8'h12);
      rdc(3'h3, 8'h40, "mul locked");
      wr(3'h0, 8'h00);
      wr(3'h2, 8'h00);
      wr(3'h3, 8'h00);
      wr(3'h5, 8'h00);
      wr(3'h4, 8'h00);
      @(posedge mclk);
      #1;
      chk(fmul, 12'h001, "mul zero");
      chk(rdiv_out, 4'h1, "refdiv zero");
      chk(rng_out, 8'h00, "range out");
      rdc(3'h4, 8'h00, "range written");
      wr(3'h1, 8'h00);
      wr(3'h0, 8'h20);
      wr(3'h0, 8'h30);
      rdc(3'h0, 8'h20, "bsel with zero range");
      chk(loop_act, 1'b0, "zero range loop");
      wr(3'h0, 8'h00);
      wr(3'h0, 8'h0e);
      rdc(3'h0, 8'h0e, "prescale written");
      chk({pre, vpr}, 4'he, "prescale out");
      wr(3'h0, 8'h00);
      wr(3'h4, 8'h40);
      wr(3'h3, 8'h40);
      wr(3'h5, 8'h01);
      @(posedge mclk);
      #1;
      chk(rng_out, 8'h40, "range restored");
      $display("test config done");
   endtask

   task automatic t_clk;
      logic [1:0] seen;
      wr(3'h0, 8'h10);
      rdc(3'h0, 8'h00, "bsel needs enable");
      rate(8, 10, "osc half");
      wr(3'h0, 8'h20);
      wr(3'h0, 8'h2f);
      wr(3'h0, 8'h30);
      rdc(3'h0, 8'h30, "bsel unlocked, prescale frozen");
      seen = 2'h0;
      repeat (16)
      begin
         @(posedge mclk);
         #1;
         seen = seen | {vco_out, !vco_out};
      end
      chk(seen, 2'h3, "vco out running");
      rate(3, 5, "vco third");
      wr(3'h0, 8'h00);
      rdc(3'h0, 8'h20, "enable held");
      $display("test clock done");
   endtask

   task automatic t_lock;
      wr(3'h1, 8'h20);
      rdc(3'h1, 8'h20, "manual track");
      wr(3'h1, 8'ha0);
      rdc(3'h1, 8'h80, "auto status");
      chk({auto_bw, cts}, 2'h3, "auto and shadow out");
      wr(3'h0, 8'ha0);
      @(posedge mclk);
      lock_det <= 1'b1;
      trk_det <= 1'b1;
      wirq(1'b1);
      rdc(3'h1, 8'he0, "locked tracking");
      rdc(3'h0, 8'he0, "flag set");
      rdc(3'h0, 8'ha0, "flag cleared");
      chk(irq_out, 1'b0, "irq cleared");
      @(posedge mclk);
      brk <= 1'b1;
      bce <= 1'b0;
      lock_det <= 1'b0;
      wirq(1'b1);
      rdc(3'h0, 8'he0, "break keep 1");
      rdc(3'h0, 8'he0, "break keep 2");
      @(posedge mclk);
      bce <= 1'b1;
      rdc(3'h0, 8'he0, "break clear");
      rdc(3'h0, 8'ha0, "break cleared");
      @(posedge mclk);
      brk <= 1'b0;
      bce <= 1'b0;
      rdc(3'h0, 8'ha0, "clear persists");
      wr(3'h0, 8'h20);
      @(posedge mclk);
      lock_det <= 1'b1;
      repeat (6) @(posedge mclk);
      #1;
      chk(irq_out, 1'b0, "no irq disabled");
      rdc(3'h0, 8'h60, "flag without enable");
      wr(3'h0, 8'ha0);
      @(posedge mclk);
      lock_det <= 1'b0;
      wirq(1'b1);
      wr(3'h1, 8'h00);
      @(posedge mclk);
      #1;
      chk(irq_out, 1'b0, "manual no irq");
      rdc(3'h1, 8'h20, "shadow back");
      rdc(3'h0, 8'h20, "manual flag zero");
      @(posedge mclk);
      lock_det <= 1'b1;
      repeat (4) @(posedge mclk);
      rdc(3'h1, 8'h20, "manual lock zero");
      chk({auto_bw, cts}, 2'h1, "manual outputs");
      $display("test lock done");
   endtask

   task automatic t_stop;
      logic bad;
      wr(3'h0, 8'h30);
      @(posedge mclk);
      stop_m <= 1'b1;
      run_halt <= 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      chk(loop_act, 1'b0, "run stop loop");
      chk(osc_en, 1'b1, "run stop osc");
      rate(8, 10, "osc in stop");
      @(posedge mclk);
      stop_m <= 1'b0;
      rdc(3'h0, 8'h20, "bsel stays clear");
      wr(3'h0, 8'h30);
      @(posedge mclk);
      stop_m <= 1'b1;
      run_halt <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      chk({osc_en, loop_act}, 2'h0, "halt stop off");
      bad = 1'b0;
      repeat (40)
      begin
         @(posedge mclk);
         #1;
         bad = bad | base_out | vco_out | irq_out;
      end
      chk(bad, 1'b0, "halt outputs low");
      @(posedge mclk);
      stop_m <= 1'b0;
      run_halt <= 1'b1;
      rdc(3'h0, 8'h20, "after halt stop");
      $display("test stop done");
   endtask

   // Main sequence: reset for 12 cycles, then each scenario
   initial
   begin
      failures = 0;
      tests_run = 0;
      resetn = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      lock_det = 1'b0;
      trk_det = 1'b0;
      stop_m = 1'b0;
      run_halt = 1'b1;
      brk = 1'b0;
      bce = 1'b0;
      repeat (12) @(posedge mclk);
      resetn <= 1'b1;
      repeat (3) @(posedge mclk);
      t_reset();
      t_cfg();
      t_clk();
      t_lock();
      t_stop();
      summarize();
   end
endmodule // tb
